// ==== rtl/soft_power_supervisor.sv ====
// Always-on supervisor for soft power on and off of the instrument frame.
// Assumes all inputs are synchronous to core_clk and the button is debounced.
`timescale 1ns/1ns
`include "soft_power_defs.svh"

////////////////////////////////////////////////////////////////////////////////
// Function
// RULE1 - Button press requests wake or shutdown
// RULE2 - Processor drives the supply control line
// RULE3 - Force supplies off after two minutes
// RULE4 - Rail undervoltage shuts supplies down immediately
// RULE5 - Notify processor on overtemperature
// RULE6 - Hard shutdown two minutes after overtemperature
// RULE7 - Faults latched until standby lost 15s
// RULE8 - Undervoltage monitor disabled one second after powerup
// RULE9 - Drive physical power on/off to supplies
// RULE10 - Timeout stops once transition completes
module soft_power_supervisor #(
  parameter logic [`TIMER_W-1:0] RESPONSE_CYC = `TIMER_W'(`RESPONSE_TIMEOUT_CYC),
  parameter logic [`TIMER_W-1:0] SETTLE_LIMIT = `TIMER_W'(`SETTLE_CYC),
  parameter logic [`TIMER_W-1:0] STANDBY_LIMIT = `TIMER_W'(`STANDBY_LOSS_CYC)
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Front panel and sensors
  input wire logic button_press,
  input wire logic [`RAIL_COUNT-1:0] rail_low,
  input wire logic overtemp_sense,
  input wire logic standby_absent,
  // Processor handshake
  input wire logic cpu_supply_on,
  output soft_power_pkg::cpu_signals_t cpu_out,
  // Supplies
  output logic [1:0] supply_enable,
  output soft_power_pkg::fault_flags_t faults
);
  ////////////////////////////////////////////////////////////////////////////
  soft_power_pkg::power_state_t state;
  soft_power_pkg::power_state_t next_state;
  soft_power_pkg::cpu_signals_t next_cpu_out;
  soft_power_pkg::fault_flags_t next_faults;
  logic [1:0] next_supply_enable;
  logic waiting;
  logic response_expired;
  logic settled;
  logic standby_cleared;
  logic any_rail_low;
  logic rail_fault;
  logic hot_fault;

  assign waiting = (state == soft_power_pkg::st_wake_wait) ||
                   (state == soft_power_pkg::st_down_wait) ||
                   (state == soft_power_pkg::st_hot_wait); // RULE10
  assign any_rail_low = |rail_low;
  assign rail_fault = settled && any_rail_low; // RULE4 RULE8
  assign hot_fault = overtemp_sense;

  // One counter serves all three handshake waits since only one is open at a time.
  timeout_counter #(.LIMIT(RESPONSE_CYC)) response_timer (
    .core_clk(core_clk),
    .reset(reset),
    .run(waiting), // RULE3 RULE6
    .expired(response_expired)
  );

  // Settling runs only while the processor holds the supplies on.
  timeout_counter #(.LIMIT(SETTLE_LIMIT)) settle_timer (
    .core_clk(core_clk),
    .reset(reset),
    .run(supply_enable[0] && cpu_supply_on), // RULE8
    .expired(settled)
  );

  timeout_counter #(.LIMIT(STANDBY_LIMIT)) standby_timer (
    .core_clk(core_clk),
    .reset(reset),
    .run(standby_absent), // RULE7
    .expired(standby_cleared)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Fault latches.
  always_comb
  begin
    next_faults = faults;
    if (rail_fault)
    begin
      next_faults.undervoltage = 1'b1; // RULE7
    end
    if (hot_fault)
    begin
      next_faults.overtemp = 1'b1; // RULE7
    end
    // A fault seen in the clear cycle wins, so no event is lost.
    if (standby_cleared && !rail_fault && !hot_fault)
    begin
      next_faults = '0; // RULE7
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      faults <= '0;
    end
    else
    begin
      faults <= next_faults;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Power state.
  always_comb
  begin
    next_state = state;
    unique case (state)
      soft_power_pkg::st_off:
      begin
        if (button_press && !faults.undervoltage && !faults.overtemp)
        begin
          next_state = soft_power_pkg::st_wake_wait; // RULE1
        end
      end
      soft_power_pkg::st_wake_wait:
      begin
        if (cpu_supply_on)
        begin
          next_state = soft_power_pkg::st_on; // RULE2 RULE10
        end
        else if (response_expired)
        begin
          next_state = soft_power_pkg::st_off; // RULE3
        end
      end
      soft_power_pkg::st_on:
      begin
        if (hot_fault || faults.overtemp)
        begin
          next_state = soft_power_pkg::st_hot_wait; // RULE5
        end
        else if (button_press)
        begin
          next_state = soft_power_pkg::st_down_wait; // RULE1
        end
        else if (!cpu_supply_on)
        begin
          next_state = soft_power_pkg::st_off; // RULE2
        end
      end
      soft_power_pkg::st_down_wait, soft_power_pkg::st_hot_wait:
      begin
        if (!cpu_supply_on || response_expired)
        begin
          next_state = soft_power_pkg::st_off; // RULE3 RULE6 RULE10
        end
      end
      default:
      begin
        next_state = soft_power_pkg::st_off;
      end
    endcase
    // A rail fault overrides every state, with no handshake.
    if (rail_fault)
    begin
      next_state = soft_power_pkg::st_off; // RULE4
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      state <= soft_power_pkg::st_off;
    end
    else
    begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Processor handshake and supply drive.
  always_comb
  begin
    next_cpu_out.wake_request = (next_state == soft_power_pkg::st_wake_wait); // RULE1
    next_cpu_out.shutdown_request = (next_state == soft_power_pkg::st_down_wait); // RULE1
    next_cpu_out.overtemp_notice = (next_state == soft_power_pkg::st_hot_wait); // RULE5
    // Supplies follow the processor line but the supervisor can always cut them.
    next_supply_enable = {`SUPPLY_COUNT{(next_state != soft_power_pkg::st_off) && cpu_supply_on}};
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cpu_out <= '0;
    end
    else
    begin
      cpu_out <= next_cpu_out;
    end
  end

  // Each supply enable pin has its own register so both switch on the same edge.
  for (genvar g = 0; g < `SUPPLY_COUNT; g++)
  begin : supply_drive
    always_ff @(posedge core_clk or posedge reset)
    begin
      if (reset)
      begin
        supply_enable[g] <= 1'b0;
      end
      else
      begin
        supply_enable[g] <= next_supply_enable[g]; // RULE9
      end
    end
  end
endmodule : soft_power_supervisor

// ==== rtl/soft_power_defs.svh ====
// Timing constants, counts and widths for the soft power supervisor.
// Assumes a 50 MHz core clock; long counts are top-level parameters.
`ifndef SOFT_POWER_DEFS_SVH
`define SOFT_POWER_DEFS_SVH
// Counts are sized to the timer width so the two minute product cannot wrap at 32 bits.
`define CLK_HZ 36'h002FAF080
`define RESPONSE_TIMEOUT_S 36'h000000078
`define RESPONSE_TIMEOUT_CYC (`RESPONSE_TIMEOUT_S * `CLK_HZ)
`define SETTLE_TIME_S 36'h000000001
`define SETTLE_CYC (`SETTLE_TIME_S * `CLK_HZ)
`define STANDBY_LOSS_S 36'h00000000F
`define STANDBY_LOSS_CYC (`STANDBY_LOSS_S * `CLK_HZ)
`define RAIL_COUNT 6
`define SUPPLY_COUNT 2
`define TIMER_W 36
`define TIMER_ZERO 36'h000000000
`define TIMER_ONE 36'h000000001
`endif

// ==== rtl/soft_power_pkg.sv ====
// Types shared by the soft power supervisor files.
// Assumes soft_power_defs.svh is on the include path.
`include "soft_power_defs.svh"
package soft_power_pkg;
  typedef enum logic [2:0] {
    st_off = 3'h0,
    st_wake_wait = 3'h1,
    st_on = 3'h2,
    st_down_wait = 3'h3,
    st_hot_wait = 3'h4
  } power_state_t;

  typedef struct packed {
    logic wake_request;
    logic shutdown_request;
    logic overtemp_notice;
  } cpu_signals_t;

  typedef struct packed {
    logic undervoltage;
    logic overtemp;
  } fault_flags_t;
endpackage : soft_power_pkg

// ==== rtl/timeout_counter.sv ====
// Up counter that raises expired after LIMIT cycles of run.
// Assumes the caller holds run high for the whole wait.
`timescale 1ns/1ns
`include "soft_power_defs.svh"
module timeout_counter #(
  parameter logic [`TIMER_W-1:0] LIMIT = `TIMER_ONE
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Control
  input wire logic run,
  // Status
  output logic expired
);
  logic [`TIMER_W-1:0] count;
  logic [`TIMER_W-1:0] next_count;
  logic next_expired;

  always_comb
  begin
    next_count = `TIMER_ZERO;
    next_expired = 1'b0;
    if (run)
    begin
      if (count >= LIMIT - `TIMER_ONE)
      begin
        next_count = count;
        next_expired = 1'b1;
      end
      else
      begin
        next_count = count + `TIMER_ONE;
      end
    end
  end

  always_ff @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      count <= `TIMER_ZERO;
      expired <= 1'b0;
    end
    else
    begin
      count <= next_count;
      expired <= next_expired;
    end
  end
endmodule : timeout_counter

// ==== verification/soft_power_assertions.sv ====
// Checker bound to the supervisor top ports.
// Assumes the bench shortens the waits to a few tens of cycles.
`timescale 1ns/1ns
module sps_chk #(
  parameter logic [35:0] RESPONSE_CYC = 36'h1,
  parameter logic [35:0] SETTLE_LIMIT = 36'h1,
  parameter logic [35:0] STANDBY_LIMIT = 36'h1
) (
  // All ports of the supervisor
  input wire logic core_clk,
  input wire logic reset,
  input wire logic button_press,
  input wire logic [5:0] rail_low,
  input wire logic overtemp_sense,
  input wire logic standby_absent,
  input wire logic cpu_supply_on,
  input wire soft_power_pkg::cpu_signals_t cpu_out,
  input wire logic [1:0] supply_enable,
  input wire soft_power_pkg::fault_flags_t faults
);
  // Bound sized for a response limit of twenty cycles.
  localparam int TMAX = 24;
  default clocking @(posedge core_clk); endclocking
  default disable iff (reset);
  chk_wake_req: assert property (
    button_press && !cpu_supply_on && !overtemp_sense && cpu_out == 0 && supply_enable == 0
    && faults == 0 |=> cpu_out.wake_request) else $error("wake request missing");
  chk_down_req: assert property (
    button_press && supply_enable == 2'h3 && cpu_out == 0 && rail_low == 0 && !overtemp_sense
    |=> cpu_out.shutdown_request) else $error("shutdown request missing");
  chk_wake_done: assert property (
    cpu_out.wake_request && cpu_supply_on && !overtemp_sense
    |=> !cpu_out.wake_request && supply_enable == 2'h3) else $error("supplies not on");
  chk_down_force: assert property (
    cpu_out.shutdown_request |-> ##[1:TMAX] supply_enable == 2'h0)
    else $error("shutdown not forced");
  chk_uv_cut: assert property (
    $rose(faults.undervoltage) |-> supply_enable == 2'h0) else $error("rail fault kept power");
  chk_uv_settle: assert property (
    $rose(supply_enable[0]) |=> !faults.undervoltage [*8]) else $error("rail fault too early");
  chk_hot_notice: assert property (
    overtemp_sense && supply_enable == 2'h3 && cpu_out == 0 && !button_press && rail_low == 0
    |=> cpu_out.overtemp_notice) else $error("overtemp notice missing");
  chk_hot_force: assert property (
    cpu_out.overtemp_notice |-> ##[1:TMAX] supply_enable == 2'h0)
    else $error("overtemp shutdown not forced");
  chk_fault_hold: assert property (
    faults != 0 && !standby_absent && !$past(standby_absent)
    |=> (faults & $past(faults)) == $past(faults))
    else $error("fault lost");
  chk_fault_refuse: assert property (
    faults != 0 && button_press && supply_enable == 0 && !overtemp_sense |=> cpu_out == 0)
    else $error("button not refused");
endmodule : sps_chk

// ==== verification/cpu_model.sv ====
// Processor side of the power handshake.
// Assumes mute makes it ignore every request, as a hung processor would.
`timescale 1ns/1ns
module cpu_model (
  input wire logic core_clk,
  input wire logic reset,
  input wire soft_power_pkg::cpu_signals_t cpu_out,
  input wire logic mute,
  output logic cpu_supply_on
);
  int n;
  always @(negedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      cpu_supply_on <= 1'b0;
      n <= 0;
    end
    else if (mute || cpu_out == 0)
      n <= 0;
    else
    begin
      n <= n + 1;
      // Answers after four cycles, well inside the response limit.
      if (n == 3)
        cpu_supply_on <= cpu_out.wake_request;
    end
  end
endmodule : cpu_model

// ==== verification/tb_top.sv ====
// Self-checking bench for the power supervisor.
// Assumes shortened limits: response 20, settle 10, standby 15 cycles.
`timescale 1ns/1ns
module tb_top;
  logic core_clk = 0, reset = 1, button_press = 0, overtemp_sense = 0;
  logic standby_absent = 0, mute = 0, cpu_supply_on;
  logic [5:0] rail_low = 6'h00;
  soft_power_pkg::cpu_signals_t cpu_out;
  logic [1:0] supply_enable;
  soft_power_pkg::fault_flags_t faults;
  int errors = 0, n_compared = 0, cycles = 0;
  soft_power_supervisor #(.RESPONSE_CYC(36'h14), .SETTLE_LIMIT(36'hA), .STANDBY_LIMIT(36'hF))
  dut_u (.core_clk(core_clk), .reset(reset), .button_press(button_press), .rail_low(rail_low),
    .overtemp_sense(overtemp_sense), .standby_absent(standby_absent),
    .cpu_supply_on(cpu_supply_on), .cpu_out(cpu_out), .supply_enable(supply_enable),
    .faults(faults));
  cpu_model cpu_u (.core_clk(core_clk), .reset(reset), .cpu_out(cpu_out), .mute(mute),
    .cpu_supply_on(cpu_supply_on));
  initial forever #10 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles > 3000)
    begin
      errors++;
      summarize();
    end
  end
  task automatic check(string what, logic [3:0] seen, logic [3:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("BAD %s exp %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic cyc(int k);
    repeat (k) @(negedge core_clk);
  endtask : cyc
  task automatic press();
    button_press = 1;
    cyc(1);
    button_press = 0;
  endtask : press
  task automatic power_on();
    press();
    for (int i = 0; i < 20 && supply_enable !== 2'h3; i++) cyc(1);
  endtask : power_on
  // A reset between tests also frees the processor model from a hung state.
  task automatic restart(string name);
    $display("test %s ended", name);
    reset = 1;
    mute = 0;
    cyc(2);
    reset = 0;
    cyc(1);
  endtask : restart
  task automatic summarize();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task automatic t_normal();
    press();
    check("wake", {1'b0, cpu_out}, 4'h4);
    for (int i = 0; i < 20 && supply_enable !== 2'h3; i++) cyc(1);
    check("on", supply_enable, 2'h3);
    cyc(30);
    check("stay_on", supply_enable, 2'h3);
    press();
    check("down", {1'b0, cpu_out}, 4'h2);
    for (int i = 0; i < 20 && supply_enable !== 2'h0; i++) cyc(1);
    check("off", {supply_enable, 2'b00}, 4'h0);
    restart("normal");
  endtask : t_normal
  task automatic t_timeout();
    power_on();
    mute = 1;
    press();
    cyc(18);
    check("still_on", supply_enable, 2'h3);
    cyc(7);
    check("forced", supply_enable, 2'h0);
    restart("timeout");
  endtask : t_timeout
  task automatic t_wake_hang();
    mute = 1;
    press();
    check("hang_wake", {1'b0, cpu_out}, 4'h4);
    cyc(18);
    check("hang_wait", {1'b0, cpu_out}, 4'h4);
    cyc(7);
    check("hang_quit", {1'b0, cpu_out}, 4'h0);
    check("hang_off", supply_enable, 2'h0);
    restart("wake_hang");
  endtask : t_wake_hang
  task automatic t_uv();
    power_on();
    rail_low = 6'h20;
    cyc(5);
    check("settle", faults, 2'h0);
    rail_low = 6'h00;
    cyc(10);
    rail_low = 6'h01;
    cyc(1);
    check("uv", {supply_enable, faults}, 4'h2);
    rail_low = 6'h00;
    press();
    check("refused", {1'b0, cpu_out}, 4'h0);
    standby_absent = 1;
    cyc(10);
    standby_absent = 0;
    check("short_loss", faults, 2'h2);
    standby_absent = 1;
    cyc(17);
    standby_absent = 0;
    check("cleared", faults, 2'h0);
    restart("undervoltage");
  endtask : t_uv
  task automatic t_hot();
    power_on();
    mute = 1;
    overtemp_sense = 1;
    cyc(1);
    check("notice", {1'b0, cpu_out}, 4'h1);
    cyc(24);
    check("hot_off", {supply_enable, faults}, 4'h1);
    overtemp_sense = 0;
    restart("overtemp");
  endtask : t_hot
  initial
  begin
    cyc(4);
    reset = 0;
    cyc(1);
    t_normal();
    t_timeout();
    t_wake_hang();
    t_uv();
    t_hot();
    summarize();
  end
endmodule : tb_top
bind soft_power_supervisor sps_chk #(.RESPONSE_CYC(RESPONSE_CYC), .SETTLE_LIMIT(SETTLE_LIMIT),
  .STANDBY_LIMIT(STANDBY_LIMIT)) chk_u (.core_clk(core_clk), .reset(reset),
  .button_press(button_press), .rail_low(rail_low), .overtemp_sense(overtemp_sense),
  .standby_absent(standby_absent), .cpu_supply_on(cpu_supply_on), .cpu_out(cpu_out),
  .supply_enable(supply_enable), .faults(faults));
